// ==== control_pin_config_select.sv ====
// Control pin decode, serial port selection, address straps and lock flag.
// Assumes pins are asynchronous to clk and four-level pins come as comparator codes.
`timescale 1ns/1ps
`default_nettype none
module control_pin_config_select
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Two-level control pins
    input  wire logic        host_out_select,
    input  wire logic        direction_select,
    input  wire logic        loop_driver_select,
    input  wire logic        enable,
    // Four-level pins as comparator codes
    input  wire logic [1:0]  host_level_select,
    input  wire logic [1:0]  serial_mode_select,
    input  wire logic [1:0]  path_select,
    input  wire logic [1:0]  coax_swing_select,
    input  wire logic [1:0]  bus_id_strap_lo,
    input  wire logic [1:0]  bus_id_strap_hi,
    // Status from the analog core and flag source control
    input  wire logic        reclock_locked,
    input  wire logic        carrier_present,
    input  wire logic        irq_pending,
    input  wire logic [1:0]  flag_source,
    input  wire logic [7:0]  spi_read_data,
    // SPI pins
    input  wire logic        ss_n,
    input  wire logic        sck,
    input  wire logic        mosi,
    output logic             miso,
    // SMBus pins and engine side
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic        sda_pull_req,
    output logic             scl_level,
    output logic             sda_level,
    // Open-drain status flag pin
    output logic             flag_out,
    output logic             flag_oe_n,
    // Decoded configuration
    output logic             host_drv_en,
    output logic             transmit_mode,
    output logic             loop_drv_en,
    output logic             power_down,
    output logic             reclock_en,
    output logic             eq_en,
    output logic [1:0]       coax_swing,
    output logic [1:0]       host_out_level,
    output logic [1:0]       host_in_eq,
    output logic             spi_mode,
    output logic             smbus_mode,
    output logic [3:0]       bus_address,
    output logic             strap_done,
    output logic [15:0]      spi_word,
    output logic             spi_word_valid
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pin_sync_if #(.W(cfg_pin_pkg::PIN_W)) pins ();

    assign pins.raw = {bus_id_strap_hi, bus_id_strap_lo, coax_swing_select, path_select,
                       serial_mode_select, host_level_select, sda_in, scl_in, mosi, sck,
                       ss_n, irq_pending, carrier_present, reclock_locked, enable,
                       loop_driver_select, direction_select, host_out_select};

    pin_sync u_sync
    (
        .clk   (clk),
        .reset (reset),
        .pins  (pins.sync_side)
    );

    wire logic [cfg_pin_pkg::PIN_W-1:0] s = pins.synced;
    wire logic en_s = s[cfg_pin_pkg::IDX_ENABLE];

    // ------------------------------------------------------------------
    // Four-level decode
    // ------------------------------------------------------------------
    cfg_pin_pkg::level_t lvl_host_ff, lvl_mode_ff, lvl_path_ff, lvl_swing_ff;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            lvl_host_ff  <= cfg_pin_pkg::LVL_HIGH;
            lvl_mode_ff  <= cfg_pin_pkg::LVL_HIGH;
            lvl_path_ff  <= cfg_pin_pkg::LVL_HIGH;
            lvl_swing_ff <= cfg_pin_pkg::LVL_HIGH;
        end
        else
        begin
            lvl_host_ff  <= cfg_pin_pkg::decode_level(s[cfg_pin_pkg::IDX_HLEVEL +: 2]);
            lvl_mode_ff  <= cfg_pin_pkg::decode_level(s[cfg_pin_pkg::IDX_MODE +: 2]);
            lvl_path_ff  <= cfg_pin_pkg::decode_level(s[cfg_pin_pkg::IDX_PATH +: 2]);
            lvl_swing_ff <= cfg_pin_pkg::decode_level(s[cfg_pin_pkg::IDX_SWING +: 2]);
        end
    end

    // ------------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------------
    // active-low host driver select, gated by enable
    wire logic nxt_host_drv = !s[cfg_pin_pkg::IDX_HOSTSEL] && en_s;
    // active-low loop driver select, gated by enable
    wire logic nxt_loop_drv = !s[cfg_pin_pkg::IDX_LOOPSEL] && en_s;
    // float is SPI, resistor-low is SMBus, others leave pin control
    wire logic nxt_spi_mode   = (lvl_mode_ff == cfg_pin_pkg::LVL_FLOAT);
    wire logic nxt_smbus_mode = (lvl_mode_ff == cfg_pin_pkg::LVL_RLOW);
    // high both on, float reclock bypass, rlow EQ bypass, low both bypass
    wire logic nxt_reclock = (lvl_path_ff == cfg_pin_pkg::LVL_HIGH) ||
                             (lvl_path_ff == cfg_pin_pkg::LVL_RLOW);
    wire logic nxt_eq      = (lvl_path_ff == cfg_pin_pkg::LVL_HIGH) ||
                             (lvl_path_ff == cfg_pin_pkg::LVL_FLOAT);
    wire logic nxt_tx      = s[cfg_pin_pkg::IDX_DIR];

    logic host_drv_ff, tx_ff, loop_drv_ff, pd_ff, reclock_ff, eq_ff;
    logic spi_mode_ff, smbus_mode_ff;
    logic [1:0] swing_ff, host_lvl_ff, host_eq_ff;

    // Configuration registers; power-down drops both drivers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            host_drv_ff   <= 1'b0;
            tx_ff         <= 1'b0;
            loop_drv_ff   <= 1'b0;
            pd_ff         <= 1'b0;
            reclock_ff    <= 1'b1;
            eq_ff         <= 1'b1;
            spi_mode_ff   <= 1'b0;
            smbus_mode_ff <= 1'b0;
            swing_ff      <= 2'h0;
            host_lvl_ff   <= 2'h0;
            host_eq_ff    <= 2'h0;
        end
        else
        begin
            host_drv_ff   <= nxt_host_drv;
            tx_ff         <= nxt_tx;
            loop_drv_ff   <= nxt_loop_drv;
            pd_ff         <= !en_s;
            reclock_ff    <= nxt_reclock;
            eq_ff         <= nxt_eq;
            spi_mode_ff   <= nxt_spi_mode;
            smbus_mode_ff <= nxt_smbus_mode;
            // one setting for both coax drivers
            swing_ff      <= lvl_swing_ff;
            host_lvl_ff   <= nxt_tx ? 2'h0 : lvl_host_ff;
            host_eq_ff    <= nxt_tx ? lvl_host_ff : 2'h0;
        end
    end

    // ------------------------------------------------------------------
    // Address straps
    // ------------------------------------------------------------------
    logic [3:0] strap_cnt_ff;
    logic       strap_done_ff;
    logic [3:0] addr_ff;
    wire  logic strap_take = !strap_done_ff && (strap_cnt_ff == cfg_pin_pkg::STRAP_WAIT);
    wire  logic [3:0] nxt_addr = {cfg_pin_pkg::decode_level(s[cfg_pin_pkg::IDX_STRAPHI +: 2]),
                                  cfg_pin_pkg::decode_level(s[cfg_pin_pkg::IDX_STRAPLO +: 2])};

    // one capture after the synchronisers settle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            strap_cnt_ff  <= 4'h0;
            strap_done_ff <= 1'b0;
            addr_ff       <= 4'h0;
        end
        else if (!strap_done_ff)
        begin
            strap_cnt_ff  <= strap_cnt_ff + 4'h1;
            strap_done_ff <= strap_take;
            if (strap_take)
                addr_ff <= nxt_addr;
        end
    end

    // ------------------------------------------------------------------
    // SPI slave
    // ------------------------------------------------------------------
    logic       sck_d_ff, ss_d_ff, miso_ff, word_vld_ff;
    logic [3:0] bit_cnt_ff;
    logic [15:0] shift_in_ff, word_ff;
    logic [7:0] shift_out_ff;
    wire  logic ss_low   = !s[cfg_pin_pkg::IDX_SS_N];
    wire  logic sck_rise = s[cfg_pin_pkg::IDX_SCK] && !sck_d_ff;
    wire  logic sck_fall = !s[cfg_pin_pkg::IDX_SCK] && sck_d_ff;
    // only selected, only in SPI mode
    wire  logic spi_act  = ss_low && spi_mode_ff;
    wire  logic ss_start = ss_low && ss_d_ff;
    wire  logic last_bit = (bit_cnt_ff == 4'(cfg_pin_pkg::SPI_BITS - 1));

    // sample MOSI on rise, shift MISO on fall
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sck_d_ff     <= 1'b0;
            ss_d_ff      <= 1'b1;
            bit_cnt_ff   <= 4'h0;
            shift_in_ff  <= 16'h0000;
            shift_out_ff <= 8'h00;
            word_ff      <= 16'h0000;
            word_vld_ff  <= 1'b0;
            miso_ff      <= 1'b0;
        end
        else
        begin
            sck_d_ff    <= s[cfg_pin_pkg::IDX_SCK];
            ss_d_ff     <= s[cfg_pin_pkg::IDX_SS_N];
            word_vld_ff <= 1'b0;
            if (!spi_act || ss_start)
            begin
                bit_cnt_ff   <= 4'h0;
                shift_out_ff <= spi_read_data;
                miso_ff      <= 1'b0;
            end
            else
            begin
                if (sck_rise)
                begin
                    shift_in_ff <= {shift_in_ff[14:0], s[cfg_pin_pkg::IDX_MOSI]};
                    bit_cnt_ff  <= bit_cnt_ff + 4'h1;
                    if (last_bit)
                    begin
                        word_ff     <= {shift_in_ff[14:0], s[cfg_pin_pkg::IDX_MOSI]};
                        word_vld_ff <= 1'b1;
                    end
                end
                if (sck_fall)
                begin
                    miso_ff      <= shift_out_ff[7];
                    shift_out_ff <= {shift_out_ff[6:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // SMBus pins and status flag
    // ------------------------------------------------------------------
    // source select picks what the flag reports
    wire logic flag_sel = (flag_source == cfg_pin_pkg::FLAG_SRC_CARRIER) ?
                              s[cfg_pin_pkg::IDX_CARRIER] :
                          (flag_source == cfg_pin_pkg::FLAG_SRC_IRQ) ?
                              s[cfg_pin_pkg::IDX_IRQ] : s[cfg_pin_pkg::IDX_LOCK];
    logic flag_oe_n_ff, sda_oe_n_ff, scl_ff, sda_ff;

    // pull low while active, release otherwise
    // SDA only ever pulled low, never driven high
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            flag_oe_n_ff <= 1'b1;
            sda_oe_n_ff  <= 1'b1;
            scl_ff       <= 1'b1;
            sda_ff       <= 1'b1;
        end
        else
        begin
            flag_oe_n_ff <= !flag_sel;
            sda_oe_n_ff  <= !(sda_pull_req && smbus_mode_ff);
            scl_ff       <= s[cfg_pin_pkg::IDX_SCL];
            sda_ff       <= s[cfg_pin_pkg::IDX_SDA];
        end
    end

    assign {host_drv_en, transmit_mode, loop_drv_en, power_down} =
           {host_drv_ff, tx_ff, loop_drv_ff, pd_ff};
    assign {reclock_en, eq_en, spi_mode, smbus_mode} =
           {reclock_ff, eq_ff, spi_mode_ff, smbus_mode_ff};
    assign {coax_swing, host_out_level, host_in_eq} = {swing_ff, host_lvl_ff, host_eq_ff};
    assign {bus_address, strap_done} = {addr_ff, strap_done_ff};
    assign {spi_word, spi_word_valid, miso} = {word_ff, word_vld_ff, miso_ff};
    // Open-drain data levels are constant low; only the enables move
    assign {sda_out, flag_out} = 2'b00;
    assign {sda_oe_n, flag_oe_n, scl_level, sda_level} =
           {sda_oe_n_ff, flag_oe_n_ff, scl_ff, sda_ff};

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_host_drv;
        !s[cfg_pin_pkg::IDX_HOSTSEL] && en_s |=> host_drv_en;
    endproperty
    a_host_drv: assert property (p_host_drv) else $error("host driver not enabled");

    property p_dir;
        s[cfg_pin_pkg::IDX_DIR] ##1 s[cfg_pin_pkg::IDX_DIR] |-> transmit_mode;
    endproperty
    a_dir: assert property (p_dir) else $error("direction not followed");

    property p_loop_drv;
        s[cfg_pin_pkg::IDX_LOOPSEL] |=> !loop_drv_en;
    endproperty
    a_loop_drv: assert property (p_loop_drv) else $error("loop driver on while deselected");

    property p_pd;
        !en_s |=> power_down && !host_drv_en && !loop_drv_en;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down not applied");

    property p_flag;
        flag_source == cfg_pin_pkg::FLAG_SRC_LOCK && s[cfg_pin_pkg::IDX_LOCK] |=> !flag_oe_n;
    endproperty
    a_flag: assert property (p_flag) else $error("lock flag not pulled low");

    property p_flag_src;
        flag_source == cfg_pin_pkg::FLAG_SRC_IRQ |=> flag_oe_n == !$past(s[cfg_pin_pkg::IDX_IRQ]);
    endproperty
    a_flag_src: assert property (p_flag_src) else $error("flag ignores irq source");

    property p_mode;
        lvl_mode_ff == cfg_pin_pkg::LVL_FLOAT |=> spi_mode && !smbus_mode;
    endproperty
    a_mode: assert property (p_mode) else $error("float mode pin did not give SPI");

    property p_spi_sel;
        spi_word_valid |-> $past(ss_low) && spi_mode;
    endproperty
    a_spi_sel: assert property (p_spi_sel) else $error("SPI word without slave select");

    property p_strap_hold;
        strap_done |=> $stable(bus_address) && strap_done;
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap address changed");

    property p_swing;
        ##1 lvl_swing_ff == cfg_pin_pkg::LVL_LOW |=> coax_swing == 2'h3;
    endproperty
    a_swing: assert property (p_swing) else $error("swing setting wrong");

    property p_sda;
        !smbus_mode |=> sda_oe_n;
    endproperty
    a_sda: assert property (p_sda) else $error("SDA pulled outside SMBus mode");

endmodule // control_pin_config_select
`default_nettype wire

// ==== cfg_pin_pkg.sv ====
// Constants and types for the control-pin and strap front end.
// Assumes every pin arrives as a plain logic level or a 2-bit comparator code.
package cfg_pin_pkg;

    // Decoded state of a four-level pin
    typedef enum logic [1:0] {LVL_HIGH, LVL_FLOAT, LVL_RLOW, LVL_LOW} level_t;

    // Raw comparator codes of a four-level pin
    localparam logic [1:0] RAW_HIGH  = 2'h3;
    localparam logic [1:0] RAW_FLOAT = 2'h2;
    localparam logic [1:0] RAW_RLOW  = 2'h1;

    // Lock flag source selection
    localparam logic [1:0] FLAG_SRC_LOCK    = 2'h0;
    localparam logic [1:0] FLAG_SRC_CARRIER = 2'h1;
    localparam logic [1:0] FLAG_SRC_IRQ     = 2'h2;

    // Bit positions in the synchronised pin vector
    localparam int PIN_W       = 24;
    localparam int IDX_HOSTSEL = 0;
    localparam int IDX_DIR     = 1;
    localparam int IDX_LOOPSEL = 2;
    localparam int IDX_ENABLE  = 3;
    localparam int IDX_LOCK    = 4;
    localparam int IDX_CARRIER = 5;
    localparam int IDX_IRQ     = 6;
    localparam int IDX_SS_N    = 7;
    localparam int IDX_SCK     = 8;
    localparam int IDX_MOSI    = 9;
    localparam int IDX_SCL     = 10;
    localparam int IDX_SDA     = 11;
    localparam int IDX_HLEVEL  = 12;
    localparam int IDX_MODE    = 14;
    localparam int IDX_PATH    = 16;
    localparam int IDX_SWING   = 18;
    localparam int IDX_STRAPLO = 20;
    localparam int IDX_STRAPHI = 22;

    // Cycles after reset release before the straps are taken
    localparam logic [3:0] STRAP_WAIT = 4'h4;
    // SPI frame length in bits
    localparam int         SPI_BITS   = 16;

    // Comparator code to decoded level
    function automatic level_t decode_level(input logic [1:0] raw);
        level_t lv;
        lv = LVL_LOW;
        if (raw == RAW_HIGH)
            lv = LVL_HIGH;
        else if (raw == RAW_FLOAT)
            lv = LVL_FLOAT;
        else if (raw == RAW_RLOW)
            lv = LVL_RLOW;
        return lv;
    endfunction

endpackage

// ==== pin_sync_if.sv ====
// Carries raw pin levels into the synchroniser and synced levels back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport sync_side (input raw, output synced);
    modport top_side  (output raw, input synced);
endinterface
`default_nettype wire

// ==== pin_sync.sv ====
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes the bits are independent levels; multi-bit codes may skew one cycle.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   reset,
    // Pin levels in, synced levels out
    pin_sync_if.sync_side pins
);
    logic [$bits(pins.raw)-1:0] meta_ff;
    logic [$bits(pins.raw)-1:0] sync_ff;

    // First stage only feeds the second
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= pins.raw;
            sync_ff <= meta_ff;
        end
    end

    assign pins.synced = sync_ff;
endmodule // pin_sync
`default_nettype wire

// ==== spi_host_model.sv ====
// Behavioural serial control master that sits on the far side of the pin front end.
// Assumes the front end samples its pins on clk and answers on miso within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
    // Clock used to pace the serial lines
    input  wire logic clk,
    // Serial pins
    input  wire logic miso,
    output logic      ss_n,
    output logic      sck,
    output logic      mosi
);
    // Four clk cycles per half link clock gives the 200 ns link clock period
    localparam int HALF = 4;

    // Idle: select high, clock parked low, data line at its pull-up level
    initial
    begin
        ss_n = 1'b1;
        sck  = 1'b0;
        mosi = 1'b1;
    end

    // One frame of nbits, MSB first; a short frame is dropped by the device
    task automatic frame(input logic [15:0] w, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk);
        ss_n <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            mosi <= w[15-i];
            repeat (HALF) @(posedge clk);
            sck <= 1'b1;
            // Read byte starts after the first falling clock edge
            if (i >= 1 && i <= 8)
                rd[8-i] = miso;
            repeat (HALF) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        ss_n <= 1'b1;
        mosi <= 1'b1;
        repeat (HALF) @(posedge clk);
    endtask
endmodule // spi_host_model
`default_nettype wire

// ==== control_pin_config_select_test.sv ====
// Self-checking bench for the control pin front end.
// Assumes the serial master model and the pin levels settle within eight clk cycles.
`timescale 1ns/1ps
`default_nettype none
module control_pin_config_select_test;
    logic clk, reset, host_out_select, direction_select, loop_driver_select, enable;
    logic [1:0] host_level_select, serial_mode_select, path_select, coax_swing_select;
    logic [1:0] bus_id_strap_lo, bus_id_strap_hi, flag_source, coax_swing, host_out_level;
    logic [1:0] host_in_eq;
    logic reclock_locked, carrier_present, irq_pending, scl_in, sda_pull_req, host_sda;
    logic miso, sda_out, sda_oe_n, scl_level, sda_level, flag_out, flag_oe_n, ss_n, sck;
    logic mosi, host_drv_en, transmit_mode, loop_drv_en, power_down, reclock_en, eq_en;
    logic spi_mode, smbus_mode, strap_done, spi_word_valid;
    logic [7:0]  spi_read_data, rd;
    logic [3:0]  bus_address;
    logic [15:0] spi_word, w;
    logic [15:0] exp_q[$];
    wire         sda_in;
    int          error_cnt, tests_run, n;
    integer      seed, r;

    // Open-drain data line with an external pull-up on the master side
    assign sda_in = sda_oe_n ? host_sda : sda_out;

    control_pin_config_select dut_u (.clk, .reset, .host_out_select, .direction_select,
        .loop_driver_select, .enable, .host_level_select, .serial_mode_select, .path_select,
        .coax_swing_select, .bus_id_strap_lo, .bus_id_strap_hi, .reclock_locked,
        .carrier_present, .irq_pending, .flag_source, .spi_read_data, .ss_n, .sck, .mosi,
        .miso, .scl_in, .sda_in, .sda_out, .sda_oe_n, .sda_pull_req, .scl_level, .sda_level,
        .flag_out, .flag_oe_n, .host_drv_en, .transmit_mode, .loop_drv_en, .power_down,
        .reclock_en, .eq_en, .coax_swing, .host_out_level, .host_in_eq, .spi_mode,
        .smbus_mode, .bus_address, .strap_done, .spi_word, .spi_word_valid);
    spi_host_model host_u (.clk, .miso, .ss_n, .sck, .mosi);

    always #12.5 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize;
        $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Word monitor: every pulse consumes the oldest expected word
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (spi_word_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(1'b1, 1'b0, "unexpected word pulse");
            else
                chk(spi_word, exp_q.pop_front(), "spi word");
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 32'h4f56;
        clk = 1'b0;
        reset = 1'b1;
        // Unconnected pin levels, straps give index 2 low and index 3 high
        {host_out_select, direction_select, loop_driver_select, enable} = 4'hb;
        {host_level_select, serial_mode_select, path_select, coax_swing_select} = 8'haa;
        {bus_id_strap_lo, bus_id_strap_hi, flag_source} = 6'h10;
        {reclock_locked, carrier_present, irq_pending, sda_pull_req} = 4'h0;
        {scl_in, host_sda, spi_read_data} = 10'h300;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        n = 0;
        while (strap_done !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (strap_done !== 1'b1)
        begin
            chk(1'b0, 1'b1, "strap timeout");
            summarize();
        end
        chk(bus_address, 4'he, "address");
        bus_id_strap_lo <= 2'h3;
        bus_id_strap_hi <= 2'h3;
        repeat (8) @(posedge clk);
        chk(bus_address, 4'he, "address held");
        chk({host_drv_en, loop_drv_en, transmit_mode, power_down}, 4'h0, "defaults");
        $display("Test straps and defaults done");
        // Random pin levels; power-down keeps both drivers off
        for (int k = 0; k < 16; k++)
        begin
            r = $random(seed);
            {coax_swing_select, path_select, enable, loop_driver_select} <= r[5:0];
            {direction_select, host_out_select, host_level_select} <= r[9:6];
            repeat (8) @(posedge clk);
            chk(host_drv_en, !host_out_select && enable, "host driver");
            chk(transmit_mode, direction_select, "direction");
            chk(loop_drv_en, !loop_driver_select && enable, "loop driver");
            chk(power_down, !enable, "power down");
            chk({reclock_en, eq_en}, {path_select[0], path_select[1]}, "path");
            chk(coax_swing, 2'h3 - coax_swing_select, "swing");
            chk(host_out_level, direction_select ? 2'h0 : 2'h3 - host_level_select, "lvl");
            chk(host_in_eq, direction_select ? 2'h3 - host_level_select : 2'h0, "eq");
        end
        $display("Test pin decode done");
        // Every flag source with random status levels
        for (int s = 0; s < 8; s++)
        begin
            r = $random(seed);
            flag_source <= s[1:0];
            {reclock_locked, carrier_present, irq_pending} <= r[2:0];
            repeat (8) @(posedge clk);
            chk({flag_out, flag_oe_n}, {1'b0, !(s[1:0] == 2'h1 ? r[1] : s[1:0] == 2'h2 ? r[0]
                : r[2])}, "flag");
        end
        flag_source <= 2'h0;
        reclock_locked <= 1'b1;
        repeat (8) @(posedge clk);
        chk(flag_oe_n, 1'b0, "lock flag");
        $display("Test flag done");
        // Every mode pin code; data line pull only in the open-drain bus mode
        for (int m = 0; m < 4; m++)
        begin
            serial_mode_select <= m[1:0];
            sda_pull_req <= 1'b1;
            scl_in <= m[0];
            // Pulled data line loops back through the pin synchroniser: allow ten edges
            repeat (10) @(posedge clk);
            chk({spi_mode, smbus_mode}, {m == 2, m == 1}, "mode");
            chk({sda_out, sda_oe_n, sda_level, scl_level},
                {1'b0, m != 1, m != 1, m[0]}, "bus pins");
        end
        {serial_mode_select, sda_pull_req, scl_in} <= 4'h9;
        repeat (8) @(posedge clk);
        $display("Test mode select done");
        // Full frames, then a short frame and a frame outside serial mode
        for (int f = 0; f < 5; f++)
        begin
            r = $random(seed);
            w = r[15:0];
            spi_read_data <= r[23:16];
            if (f == 4)
                serial_mode_select <= 2'h1;
            repeat (8) @(posedge clk);
            if (f < 3)
                exp_q.push_back(w);
            host_u.frame(w, f == 3 ? 8 : 16, rd);
            if (f < 3)
                chk(rd, r[23:16], "read byte");
            repeat (8) @(posedge clk);
        end
        chk(exp_q.size(), 16'h0, "words left");
        $display("Test serial frames done");
        summarize();
    end
endmodule // control_pin_config_select_test
`default_nettype wire
